// ===== hdl/adc_seq_pkg.sv
package adc_seq_pkg;
	// clock
	localparam int unsigned CLOCK_PERIOD_NS = 4;
	localparam int unsigned CYCLES_PER_US = 1000 / CLOCK_PERIOD_NS;

	// widths
	localparam int unsigned SELECT_WIDTH = 5;
	localparam int unsigned RESULT_WIDTH = 8;
	localparam int unsigned SETTLE_FIELD_WIDTH = 4;
	localparam int unsigned OUTPUT_COUNT = 12;
	localparam int unsigned SETTLE_COUNT_WIDTH = 24;

	// reset values
	localparam logic [4:0] SELECT_RESET = 5'h00;
	localparam logic [7:0] RESULT_RESET = 8'h00;

	// channel select codes
	localparam logic [4:0] CODE_REFERENCE_VOLTAGE = 5'h00;
	localparam logic [4:0] CODE_SUPPLY_VOLTAGE = 5'h01;
	localparam logic [4:0] CODE_REGULATOR_OUTPUT = 5'h02;
	localparam logic [4:0] CODE_DIE_TEMPERATURE_SENSOR = 5'h03;
	localparam logic [4:0] CODE_REFERENCE_CURRENT = 5'h04;
	localparam logic [4:0] CODE_MAX_OUTPUT_VOLTAGE = 5'h05;
	localparam logic [4:0] CODE_BATTERY_VOLTAGE = 5'h06;
	localparam logic [4:0] CODE_FIRST_OUTPUT = 5'h10;
	localparam logic [4:0] CODE_LAST_OUTPUT = 5'h1B;

	// successive-approximation bit time
	localparam int unsigned SAR_BIT_NS = 40;
	localparam int unsigned SAR_BIT_CYCLES = (SAR_BIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	// output settle delay per field code, in microseconds
	localparam int unsigned SETTLE_US [16] = '{
		100, 20, 30, 50, 80, 150, 200, 300, 500, 800, 1000, 1200, 1500, 2000, 3000, 5000
	};

	// a full pwm period is bounded by two period starts after selection
	localparam logic [1:0] PERIOD_STARTS_NEEDED = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_BACKGROUND = 3'b001,
		ST_PREPARE = 3'b010,
		ST_WAIT_ON = 3'b011,
		ST_SETTLE = 3'b100,
		ST_CONVERT = 3'b101,
		ST_HOLD = 3'b110
	} seq_state_type;
endpackage

// ===== hdl/sar_engine.sv
`timescale 1ns/1ps
module sar_engine (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	input wire logic abort,
	input wire logic compare_above,
	output logic [7:0] dac_code,
	output logic busy,
	output logic done,
	output logic [7:0] code
);
	logic [7:0] trial_q;
	logic [7:0] trial_d;
	logic [7:0] bit_q;
	logic [3:0] wait_q;
	logic busy_q;
	logic done_q;
	logic [7:0] code_q;
	wire bit_end = busy_q && (wait_q == 4'(adc_seq_pkg::SAR_BIT_CYCLES - 1));
	wire last_bit = bit_q[0];

	// keep the trial bit when the input lies above the dac level
	assign trial_d = compare_above ? trial_q : (trial_q & ~bit_q);
	assign dac_code = trial_q;
	assign busy = busy_q;
	assign done = done_q;
	assign code = code_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trial_q <= 8'h00;
			bit_q <= 8'h00;
			wait_q <= 4'h0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			code_q <= 8'h00;
		end else begin
			done_q <= 1'b0;
			if (abort) begin
				busy_q <= 1'b0;
				trial_q <= 8'h00;
			end else if (start) begin
				busy_q <= 1'b1;
				bit_q <= 8'h80;
				trial_q <= 8'h80;
				wait_q <= 4'h0;
			end else if (bit_end) begin
				wait_q <= 4'h0;
				bit_q <= bit_q >> 1;
				trial_q <= trial_d | (bit_q >> 1);
				if (last_bit) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
					code_q <= trial_d;
				end
			end else if (busy_q) begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule

// ===== hdl/adc_sequencer_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - while no request is pending, keep converting supply into its own result
// - a select write, other than a repeated 05h, starts a new request and clears the done flag
// - on completion load the result register and set the done flag
// - a completed read of the result clears the done flag
// - enabled output: sample after it turns on plus the settle delay
// - disabled output: sample the off-state voltage with no delay
// - codes 00h-06h are internal sources; 07h-0Fh reserved
// - codes 10h-1Bh select outputs 0-11; 1Ch-1Fh reserved
// - maximum-output code records the highest voltage over all twelve outputs
// - maximum-output result valid only after one full pwm period
// - no maximum-output refresh while the select stays at its code
module adc_sequencer_ctrl #(
	parameter int unsigned CYCLES_PER_US = adc_seq_pkg::CYCLES_PER_US
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic select_write,
	input wire logic [4:0] select_wdata,
	input wire logic result_read_done,
	input wire logic [11:0] output_channel_enable,
	input wire logic [11:0] led_output_on,
	input wire logic [3:0] diag_settle_delay,
	input wire logic pwm_period_start,
	input wire logic comparator_pin,
	output logic [4:0] adc_channel_select,
	output logic [7:0] adc_result,
	output logic conversion_done_flag,
	output logic [7:0] supply_scan_result,
	output logic [4:0] analog_mux_select,
	output logic [7:0] dac_code
);
	localparam int unsigned SETTLE_COUNT_W = adc_seq_pkg::SETTLE_COUNT_WIDTH;

	adc_seq_pkg::seq_state_type state_q;
	logic [4:0] select_q;
	logic [7:0] result_q;
	logic done_q;
	logic [7:0] supply_q;
	logic [4:0] mux_q;
	logic [3:0] max_index_q;
	logic [7:0] max_q;
	logic max_all_seen_q;
	logic [1:0] periods_q;
	logic on_prev_q;
	logic [SETTLE_COUNT_W-1:0] settle_q;
	logic compare_meta_q;
	logic compare_sync_q;
	logic sar_start;
	logic sar_abort;
	logic sar_done;
	logic [7:0] sar_code;

	// a repeated maximum-output write is ignored so the held result is not disturbed
	wire repeat_max = (select_wdata == adc_seq_pkg::CODE_MAX_OUTPUT_VOLTAGE) &&
		(select_q == adc_seq_pkg::CODE_MAX_OUTPUT_VOLTAGE);
	wire accept_write = select_write && !repeat_max;
	wire max_mode = (select_q == adc_seq_pkg::CODE_MAX_OUTPUT_VOLTAGE);
	wire is_output = (select_q >= adc_seq_pkg::CODE_FIRST_OUTPUT) &&
		(select_q <= adc_seq_pkg::CODE_LAST_OUTPUT);
	wire is_internal = (select_q <= adc_seq_pkg::CODE_BATTERY_VOLTAGE);
	wire [3:0] select_index = 4'(select_q - adc_seq_pkg::CODE_FIRST_OUTPUT);
	wire [3:0] target_index = max_mode ? max_index_q : select_index;
	wire [4:0] target_code = max_mode ? 5'(adc_seq_pkg::CODE_FIRST_OUTPUT + 5'(max_index_q))
		: select_q;
	wire target_is_output = max_mode || is_output;
	wire target_enabled = output_channel_enable[target_index];
	wire target_on = led_output_on[target_index];
	wire [SETTLE_COUNT_W-1:0] settle_load = SETTLE_COUNT_W'(
		adc_seq_pkg::SETTLE_US[diag_settle_delay] * CYCLES_PER_US - 1);
	wire last_index = (max_index_q == 4'(adc_seq_pkg::OUTPUT_COUNT - 1));
	wire period_complete = (periods_q >= adc_seq_pkg::PERIOD_STARTS_NEEDED);
	wire [7:0] max_next = (sar_code > max_q) ? sar_code : max_q;
	wire max_finish = max_mode && (max_all_seen_q || last_index) && period_complete;
	// a write in the completing cycle restarts, so its flag clear must not be overridden
	wire request_done = (state_q == adc_seq_pkg::ST_CONVERT) && sar_done &&
		(!max_mode || max_finish) && !accept_write;
	wire reserved_done = (state_q == adc_seq_pkg::ST_PREPARE) && !is_internal && !is_output &&
		!accept_write;

	// conversion start: direct for internal sources and disabled outputs
	assign sar_start = (state_q == adc_seq_pkg::ST_IDLE && !accept_write) ||
		(state_q == adc_seq_pkg::ST_PREPARE && !accept_write && !reserved_done &&
		(!target_is_output || !target_enabled)) ||
		(state_q == adc_seq_pkg::ST_SETTLE && !accept_write && target_on &&
		settle_q == '0);
	// clearing the trial code on every accepted write keeps the dac quiet while the first output after that write settles
	assign sar_abort = accept_write;

	assign adc_channel_select = select_q;
	assign adc_result = result_q;
	assign conversion_done_flag = done_q;
	assign supply_scan_result = supply_q;
	assign analog_mux_select = mux_q;

	sar_engine sar (
		.clock(clock),
		.rst(rst),
		.start(sar_start),
		.abort(sar_abort),
		.compare_above(compare_sync_q),
		.dac_code(dac_code),
		.busy(),
		.done(sar_done),
		.code(sar_code)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			compare_meta_q <= 1'b0;
			compare_sync_q <= 1'b0;
		end else begin
			compare_meta_q <= comparator_pin;
			compare_sync_q <= compare_meta_q;
		end
	end

	// done flag: setting wins over a read clear in the same cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			done_q <= 1'b0;
		end else if (request_done || reserved_done) begin
			done_q <= 1'b1;
		end else if (accept_write || result_read_done) begin
			done_q <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			select_q <= adc_seq_pkg::SELECT_RESET;
			result_q <= adc_seq_pkg::RESULT_RESET;
			supply_q <= adc_seq_pkg::RESULT_RESET;
		end else begin
			if (accept_write) begin
				select_q <= select_wdata;
			end
			if (request_done) begin
				result_q <= max_mode ? max_next : sar_code;
			end else if (reserved_done) begin
				result_q <= adc_seq_pkg::RESULT_RESET;
			end
			if (state_q == adc_seq_pkg::ST_BACKGROUND && sar_done && !accept_write) begin
				supply_q <= sar_code;
			end
		end
	end

	// pwm period starts counted from the maximum-output selection
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			periods_q <= 2'h0;
		end else if (accept_write) begin
			periods_q <= 2'h0;
		end else if (pwm_period_start && !period_complete) begin
			periods_q <= periods_q + 2'h1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= adc_seq_pkg::ST_IDLE;
			mux_q <= adc_seq_pkg::CODE_SUPPLY_VOLTAGE;
			max_index_q <= 4'h0;
			max_q <= 8'h00;
			max_all_seen_q <= 1'b0;
			on_prev_q <= 1'b0;
			settle_q <= '0;
		end else begin
			on_prev_q <= target_on;
			if (accept_write) begin
				state_q <= adc_seq_pkg::ST_PREPARE;
				max_index_q <= 4'h0;
				max_q <= 8'h00;
				max_all_seen_q <= 1'b0;
			end else begin
				unique case (state_q)
					adc_seq_pkg::ST_IDLE: begin
						mux_q <= adc_seq_pkg::CODE_SUPPLY_VOLTAGE;
						state_q <= adc_seq_pkg::ST_BACKGROUND;
					end
					adc_seq_pkg::ST_BACKGROUND: begin
						if (sar_done) begin
							state_q <= adc_seq_pkg::ST_IDLE;
						end
					end
					adc_seq_pkg::ST_PREPARE: begin
						mux_q <= target_code;
						if (reserved_done) begin
							state_q <= adc_seq_pkg::ST_IDLE;
						end else if (sar_start) begin
							state_q <= adc_seq_pkg::ST_CONVERT;
						end else begin
							state_q <= adc_seq_pkg::ST_WAIT_ON;
						end
					end
					adc_seq_pkg::ST_WAIT_ON: begin
						// only a fresh turn-on edge starts the settle timer
						if (target_on && !on_prev_q) begin
							settle_q <= settle_load;
							state_q <= adc_seq_pkg::ST_SETTLE;
						end
					end
					adc_seq_pkg::ST_SETTLE: begin
						if (!target_on) begin
							state_q <= adc_seq_pkg::ST_WAIT_ON;
						end else if (sar_start) begin
							state_q <= adc_seq_pkg::ST_CONVERT;
						end else begin
							settle_q <= settle_q - SETTLE_COUNT_W'(1);
						end
					end
					adc_seq_pkg::ST_CONVERT: begin
						if (sar_done) begin
							if (!max_mode) begin
								state_q <= adc_seq_pkg::ST_IDLE;
							end else if (max_finish) begin
								state_q <= adc_seq_pkg::ST_HOLD;
							end else begin
								max_q <= max_next;
								max_index_q <= last_index ? 4'h0 : max_index_q + 4'h1;
								max_all_seen_q <= max_all_seen_q || last_index;
								state_q <= adc_seq_pkg::ST_PREPARE;
							end
						end
					end
					adc_seq_pkg::ST_HOLD: begin
						state_q <= adc_seq_pkg::ST_IDLE;
					end
					default: begin
						state_q <= adc_seq_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end
endmodule

// ===== sim/adc_sequencer_ctrl_props.sv
`timescale 1ns/1ps
module adc_sequencer_ctrl_props (
	input wire logic clock,
	input wire logic rst,
	input wire logic select_write,
	input wire logic [4:0] select_wdata,
	input wire logic result_read_done,
	input wire logic [11:0] output_channel_enable,
	input wire logic [4:0] adc_channel_select,
	input wire logic [7:0] adc_result,
	input wire logic conversion_done_flag,
	input wire logic [7:0] supply_scan_result,
	input wire logic [4:0] analog_mux_select,
	input wire logic [7:0] dac_code
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	wire done = conversion_done_flag;
	wire [4:0] wd = select_wdata;
	wire again_max = select_write && wd == 5'h05 && adc_channel_select == 5'h05;
	wire rsv = select_write && (wd == 5'h07 || wd[4:3] == 2'h1 || wd[4:2] == 3'h7);
	wire off_out = select_write && wd[4] && wd[3:0] < 4'hC && !output_channel_enable[wd[3:0]];
	AST_WRITE_CLEARS: assert property (select_write && !again_max |=> !done
		&& adc_channel_select == $past(wd)) else $error("write not taken");
	AST_READ_CLEARS: assert property (result_read_done && done && !select_write
		|=> !done) else $error("read did not clear flag");
	AST_RESULT_HOLDS: assert property (done && $past(done) |-> $stable(adc_result))
		else $error("result moved");
	AST_RESULT_WITH_FLAG: assert property ($changed(adc_result) |-> done)
		else $error("result without flag");
	AST_MAX_FROZEN: assert property (adc_channel_select == 5'h05 && done
		&& !result_read_done && (!select_write || again_max) |=> done && $stable(adc_result))
		else $error("max result refreshed");
	AST_RESERVED: assert property (rsv ##1 (!select_write && !result_read_done)[*2]
		|-> done && adc_result == 8'h00) else $error("reserved code converted");
	AST_SCAN_SUPPLY: assert property ($changed(supply_scan_result)
		|-> $past(analog_mux_select, 2) == 5'h01) else $error("scan from wrong source");
	AST_OFF_NO_DELAY: assert property (off_out ##1 (!select_write)[*3]
		|-> ##[0:3] dac_code == 8'h80) else $error("disabled output waited");
	cover property (again_max);
	cover property (rsv);
	cover property ($rose(done) && adc_channel_select == 5'h05);
endmodule
bind adc_sequencer_ctrl adc_sequencer_ctrl_props u_props (.clock(clock), .rst(rst),
	.select_write(select_write), .select_wdata(select_wdata),
	.result_read_done(result_read_done), .output_channel_enable(output_channel_enable),
	.adc_channel_select(adc_channel_select), .adc_result(adc_result),
	.conversion_done_flag(conversion_done_flag), .supply_scan_result(supply_scan_result),
	.analog_mux_select(analog_mux_select), .dac_code(dac_code));

// ===== sim/master_model.sv
`timescale 1ns/1ps
module master_model (
	input wire logic clock,
	input wire logic [7:0] adc_result,
	output logic select_write,
	output logic [4:0] select_wdata,
	output logic result_read_done
);
	initial begin
		select_write = 1'b0;
		select_wdata = 5'h00;
		result_read_done = 1'b0;
	end
	// released data shows the inverse so a stale code cannot pass for a fresh one
	task automatic write_select(input logic [4:0] code);
		@(posedge clock);
		#1 select_write = 1'b1;
		select_wdata = code;
		@(posedge clock);
		#1 select_write = 1'b0;
		select_wdata = ~code;
	endtask
	task automatic read_result(output logic [7:0] value);
		@(posedge clock);
		#1 result_read_done = 1'b1;
		@(posedge clock);
		value = adc_result;
		#1 result_read_done = 1'b0;
	endtask
endmodule

// ===== sim/adc_sequencer_ctrl_tb.sv
`timescale 1ns/1ps
module adc_sequencer_ctrl_tb;
	logic clock = 1'b0;
	logic rst;
	logic [11:0] output_channel_enable;
	logic [11:0] led_output_on;
	logic pwm_period_start;
	logic [3:0] settle_code;
	logic [7:0] got;
	logic [4:0] rsv [5] = '{5'h07, 5'h08, 5'h0F, 5'h1C, 5'h1F};
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	wire select_write, result_read_done, conversion_done_flag, comparator_pin;
	wire [4:0] select_wdata, adc_channel_select, analog_mux_select;
	wire [7:0] adc_result, supply_scan_result, dac_code, on_level, level;
	// each source has its own level; an output in its off phase reads 05
	assign on_level = {3'h0, analog_mux_select} * 8'h07 + 8'h03;
	assign level = (analog_mux_select[4] && !led_output_on[analog_mux_select[3:0]])
		? 8'h05 : on_level;
	assign comparator_pin = level >= dac_code;
	always #2 clock = ~clock;
	adc_sequencer_ctrl #(.CYCLES_PER_US(1)) u_dut (.clock(clock), .rst(rst),
		.select_write(select_write), .select_wdata(select_wdata),
		.result_read_done(result_read_done), .output_channel_enable(output_channel_enable),
		.led_output_on(led_output_on), .diag_settle_delay(settle_code),
		.pwm_period_start(pwm_period_start), .comparator_pin(comparator_pin),
		.adc_channel_select(adc_channel_select), .adc_result(adc_result),
		.conversion_done_flag(conversion_done_flag), .supply_scan_result(supply_scan_result),
		.analog_mux_select(analog_mux_select), .dac_code(dac_code));
	master_model u_master (.clock(clock), .adc_result(adc_result),
		.select_write(select_write), .select_wdata(select_wdata),
		.result_read_done(result_read_done));
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
		num_checks++;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, seen);
			bad_count++;
		end
	endtask
	task automatic wait_done();
		for (int i = 0; i < 3000 && conversion_done_flag !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
	endtask
	task automatic conv(input logic [4:0] code, input logic [7:0] exp);
		u_master.write_select(code);
		check("flag", 8'h00, {7'h0, conversion_done_flag});
		wait_done();
		check("result", exp, adc_result);
		u_master.read_result(got);
		check("read", exp, got);
		check("flag", 8'h00, {7'h0, conversion_done_flag});
	endtask
	task automatic pulse();
		@(posedge clock);
		#1 pwm_period_start = 1'b1;
		@(posedge clock);
		#1 pwm_period_start = 1'b0;
	endtask
	// settle is the table delay in cycles at one cycle per microsecond
	task automatic on_run(input logic [3:0] delay, input int settle);
		settle_code = delay;
		led_output_on = 12'h000;
		u_master.write_select(5'h1B);
		repeat (150) @(posedge clock);
		#1 led_output_on = 12'h800;
		repeat (settle - 5) @(posedge clock);
		#1 check("settle", 8'h00, dac_code);
		repeat (10) @(posedge clock);
		#1 check("start", 8'h80, dac_code);
		wait_done();
		check("on", 8'hC0, adc_result);
	endtask
	task automatic max_run(input logic [7:0] exp);
		u_master.write_select(5'h05);
		pulse();
		repeat (1500) @(posedge clock);
		check("early", 8'h00, {7'h0, conversion_done_flag});
		pulse();
		wait_done();
		check("max", exp, adc_result);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		rst = 1'b1;
		output_channel_enable = 12'h000;
		led_output_on = 12'h000;
		pwm_period_start = 1'b0;
		settle_code = 4'h1;
		repeat (5) @(posedge clock);
		#1 rst = 1'b0;
		check("select", 8'h00, {3'h0, adc_channel_select});
		repeat (200) @(posedge clock);
		check("scan", 8'h0A, supply_scan_result);
		for (int c = 0; c < 7; c++) begin
			if (c != 5) conv(c[4:0], 8'(c * 7 + 3));
		end
		foreach (rsv[i]) conv(rsv[i], 8'h00);
		conv(5'h10, 8'h05);
		u_master.write_select(5'h02);
		conv(5'h03, 8'h18);
		output_channel_enable = 12'h800;
		on_run(4'h1, 20);
		on_run(4'h0, 100);
		output_channel_enable = 12'h000;
		led_output_on = 12'hFFF;
		max_run(8'hC0);
		led_output_on = 12'h000;
		u_master.write_select(5'h05);
		repeat (300) @(posedge clock);
		check("held", 8'hC0, adc_result);
		check("held flag", 8'h01, {7'h0, conversion_done_flag});
		u_master.write_select(5'h00);
		max_run(8'h05);
		complete_run();
	end
endmodule
